// File: hw/aipc_pkg.sv
// constants, field layout and carrier types for the audio input port block
// assumes a 10 MHz system clock and a separate serial bit clock from the source
//
// Behaviour
// - pulse-density data: rising if 0, falling if 1
// - role bit: 0 slave, 1 drives clock
// - clock source: 0 ground, 1 dedicated clock pin
// - clock gate: 0 holds clock off, 1 active
// - synced amp: family 0 is 48k, 1 44.1k
// - sync bit: 0 free running, 1 synced
// - auto-rate bit 0 detects rate, 1 uses programmed
// - rate code 011/100/101 picks 1x/2x/4x rates
// - frame start: rise if 0, fall if 1
// - sample left-justified if 0, right-justified if 1
// - slot 0 starts offset bit clocks after start
// - receive data captured rising if 0, falling if 1
`default_nettype none

package aipc_pkg;

   // ------------------------------------------------------------
   // register offsets and values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] AMP_SYNC_ADDR = 8'h08;
   localparam logic [7:0] PD_CFG_ADDR = 8'h09;
   localparam logic [7:0] FRAME_CFG_ADDR = 8'h0a;
   localparam logic [7:0] SLOT_CFG_ADDR = 8'h0b;
   localparam logic [7:0] AMP_SYNC_RST = 8'h00;
   localparam logic [7:0] PD_CFG_RST = 8'h08;
   localparam logic [7:0] FRAME_CFG_RST = 8'h07;
   localparam logic [7:0] SLOT_CFG_RST = 8'h02;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int AMP_SYNC_BIT = 6;
   localparam int PD_EDGE_BIT = 7;
   localparam int PD_ROLE_BIT = 5;
   localparam int PD_SRC_BIT = 3;
   localparam int PD_GATE_BIT = 1;
   localparam int FAMILY_BIT = 5;
   localparam int AUTO_RATE_BIT = 4;
   localparam int RATE_LSB = 1;
   localparam int FS_POL_BIT = 0;
   localparam int JUSTIFY_BIT = 6;
   localparam int OFFSET_LSB = 1;
   localparam int RX_EDGE_BIT = 0;

   // ------------------------------------------------------------
   // bus sample rate codes
   // ------------------------------------------------------------
   localparam logic [2:0] RATE_1X = 3'h3;
   localparam logic [2:0] RATE_2X = 3'h4;
   localparam logic [2:0] RATE_4X = 3'h5;

   // ------------------------------------------------------------
   // timing, in ns and in system clock cycles
   // ------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int FRAME_1X_NS = 20833;
   localparam int FRAME_2X_NS = 10417;
   localparam int FRAME_4X_NS = 5208;
   localparam int FRAME_1X_CYC = FRAME_1X_NS / CLK_NS;
   localparam int FRAME_2X_CYC = FRAME_2X_NS / CLK_NS;
   localparam int FRAME_4X_CYC = FRAME_4X_NS / CLK_NS;
   localparam logic [11:0] TH_1X_2X = 12'((FRAME_1X_CYC + FRAME_2X_CYC) / 2);
   localparam logic [11:0] TH_2X_4X = 12'((FRAME_2X_CYC + FRAME_4X_CYC) / 2);
   localparam int PD_CLK_NS = 400;
   localparam int PD_HALF_CYC = PD_CLK_NS / 2 / CLK_NS;
   localparam logic [3:0] PD_DIV_LAST = 4'(PD_HALF_CYC - 1);

   // ------------------------------------------------------------
   // slot geometry, fixed here since width setup lives elsewhere
   // ------------------------------------------------------------
   localparam logic [7:0] SLOT_LEN = 8'h20;
   localparam logic [7:0] WORD_LEN = 8'h10;

   typedef logic [15:0] aipc_sample_t;

   typedef struct packed {
      logic fs_fall;
      logic right_just;
      logic [4:0] offset;
      logic fall_edge;
   } aipc_rx_cfg_s;

endpackage

`default_nettype wire

// File: hw/aipc_tdm_rx.sv
// receive framing of the time-division port, on the serial bit clock
// assumes config is quasi-static and is resynchronised here
`default_nettype none

module aipc_tdm_rx (
   // link pins
   input wire logic serial_bit_clock,
   input wire logic frame_sync,
   input wire logic serial_data_in,
   // system side
   input wire logic sys_rst,
   input wire aipc_pkg::aipc_rx_cfg_s cfg,
   output var aipc_pkg::aipc_sample_t word,
   output logic word_toggle,
   output logic frame_toggle
);

   // ------------------------------------------------------------
   // reset and config crossing
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_q;
   aipc_pkg::aipc_rx_cfg_s cfg_meta;
   aipc_pkg::aipc_rx_cfg_s cfg_q;

   always_ff @(posedge serial_bit_clock)
   begin
      rst_meta <= sys_rst;
      rst_q <= rst_meta;
      cfg_meta <= cfg;
      cfg_q <= cfg_meta;
   end

   // ------------------------------------------------------------
   // capture on either edge
   // ------------------------------------------------------------
   logic fs_fall_smp;
   logic dat_fall_smp;

   always_ff @(negedge serial_bit_clock)
   begin
      fs_fall_smp <= frame_sync;
      dat_fall_smp <= serial_data_in;
   end

   // falling-edge samples are consumed at the next rising edge
   wire fs_now = cfg_q.fall_edge ? fs_fall_smp : frame_sync;
   wire dat_now = cfg_q.fall_edge ? dat_fall_smp : serial_data_in;

   logic fs_prev;
   wire frame_start = cfg_q.fs_fall ? (fs_prev & ~fs_now) : (~fs_prev & fs_now);

   // ------------------------------------------------------------
   // bit position within the frame
   // ------------------------------------------------------------
   logic [7:0] pos;
   wire [7:0] pos_inc = (pos == 8'hff) ? pos : pos + 8'h01;
   wire [7:0] cur_pos = frame_start ? 8'h00 : pos_inc;
   wire [7:0] offs = {3'h0, cfg_q.offset};
   wire in_slot = (cur_pos >= offs) && (cur_pos < offs + aipc_pkg::SLOT_LEN);
   wire [7:0] idx = cur_pos - offs;
   wire [7:0] first_bit =
      cfg_q.right_just ? aipc_pkg::SLOT_LEN - aipc_pkg::WORD_LEN : 8'h00;
   wire take = in_slot && (idx >= first_bit) && (idx < first_bit + aipc_pkg::WORD_LEN);
   wire last = take && (idx == first_bit + aipc_pkg::WORD_LEN - 8'h01);

   aipc_pkg::aipc_sample_t shift;
   wire [15:0] next_shift = {shift[14:0], dat_now};

   always_ff @(posedge serial_bit_clock)
   begin
      if (rst_q)
      begin
         // track the pin in reset so the first frame edge is not lost or faked
         fs_prev <= fs_now;
         pos <= 8'hff;
         shift <= 16'h0000;
         word <= 16'h0000;
         word_toggle <= 1'b0;
         frame_toggle <= 1'b0;
      end
      else
      begin
         fs_prev <= fs_now;
         pos <= cur_pos;
         if (take)
            shift <= next_shift;
         if (last)
         begin
            word <= next_shift;
            word_toggle <= ~word_toggle;
         end
         if (frame_start)
            frame_toggle <= ~frame_toggle;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_FRAME_EDGE: assert property (@(posedge serial_bit_clock) disable iff (rst_q)
      (cfg_q.fs_fall && fs_prev && !fs_now) |=> (pos == 8'h00))
      else $error("falling frame sync did not restart the frame");

   AST_LEFT_END: assert property (@(posedge serial_bit_clock) disable iff (rst_q)
      ($changed(word_toggle) && !$past(cfg_q.right_just))
         |-> ($past(cur_pos) == $past(offs) + aipc_pkg::WORD_LEN - 8'h01))
      else $error("left justified word ended at wrong bit");

   AST_RIGHT_END: assert property (@(posedge serial_bit_clock) disable iff (rst_q)
      ($changed(word_toggle) && $past(cfg_q.right_just))
         |-> ($past(cur_pos) == $past(offs) + aipc_pkg::SLOT_LEN - 8'h01))
      else $error("slot 0 did not end offset plus slot length after frame start");

endmodule

`default_nettype wire

// File: hw/aipc_audio_in.sv
// audio input port configuration: registers, pulse-density input, rate detection
// assumes a simple register port from the control interface and
// a time-division source that owns the serial bit clock
`default_nettype none

module aipc_audio_in (
   // system
   input wire logic mclk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_ack,
   // pulse-density input a
   input wire logic pd_data_in_a,
   input wire logic pd_clock_pin_a_in,
   output logic pd_clock_pin_a_out,
   output logic pd_clock_pin_a_oe,
   output logic pd_bit,
   output logic pd_bit_valid,
   // time-division link
   input wire logic serial_bit_clock,
   input wire logic frame_sync,
   input wire logic serial_data_in,
   // receive and rate results
   output var aipc_pkg::aipc_sample_t rx_sample,
   output logic rx_sample_valid,
   output logic [2:0] active_rate_code,
   output logic amp_audio_clock_sync,
   output logic amp_rate_44k1
);

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [7:0] amp_sync_config;
   logic [7:0] pulse_density_input_one_config;
   logic [7:0] frame_rate_config;
   logic [7:0] receive_slot_format_config;

   wire hit_amp = (reg_addr == aipc_pkg::AMP_SYNC_ADDR);
   wire hit_pd = (reg_addr == aipc_pkg::PD_CFG_ADDR);
   wire hit_frame = (reg_addr == aipc_pkg::FRAME_CFG_ADDR);
   wire hit_slot = (reg_addr == aipc_pkg::SLOT_CFG_ADDR);

   // reserved bits are kept in full so software reads back what it wrote
   wire [7:0] next_rdata =
      hit_amp ? amp_sync_config :
      hit_pd ? pulse_density_input_one_config :
      hit_frame ? frame_rate_config :
      hit_slot ? receive_slot_format_config : 8'h00;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         amp_sync_config <= aipc_pkg::AMP_SYNC_RST;
         pulse_density_input_one_config <= aipc_pkg::PD_CFG_RST;
         frame_rate_config <= aipc_pkg::FRAME_CFG_RST;
         receive_slot_format_config <= aipc_pkg::SLOT_CFG_RST;
         reg_rdata <= 8'h00;
         reg_ack <= 1'b0;
      end
      else
      begin
         if (reg_wr && hit_amp)
            amp_sync_config <= reg_wdata;
         if (reg_wr && hit_pd)
            pulse_density_input_one_config <= reg_wdata;
         if (reg_wr && hit_frame)
            frame_rate_config <= reg_wdata;
         if (reg_wr && hit_slot)
            receive_slot_format_config <= reg_wdata;
         reg_rdata <= (reg_rd && !reg_wr) ? next_rdata : 8'h00;
         reg_ack <= reg_rd | reg_wr;
      end
   end

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   wire pd_in_a_capture_edge = pulse_density_input_one_config[aipc_pkg::PD_EDGE_BIT];
   wire pd_in_a_clock_role = pulse_density_input_one_config[aipc_pkg::PD_ROLE_BIT];
   wire pd_in_a_clock_source = pulse_density_input_one_config[aipc_pkg::PD_SRC_BIT];
   wire pd_in_a_clock_gate = pulse_density_input_one_config[aipc_pkg::PD_GATE_BIT];
   wire sync_bit = amp_sync_config[aipc_pkg::AMP_SYNC_BIT];
   wire family_bit = frame_rate_config[aipc_pkg::FAMILY_BIT];
   wire auto_rate_off = frame_rate_config[aipc_pkg::AUTO_RATE_BIT];
   wire [2:0] bus_sample_rate_code = frame_rate_config[aipc_pkg::RATE_LSB +: 3];

   aipc_pkg::aipc_rx_cfg_s rx_cfg;
   assign rx_cfg = {frame_rate_config[aipc_pkg::FS_POL_BIT],
                    receive_slot_format_config[aipc_pkg::JUSTIFY_BIT],
                    receive_slot_format_config[aipc_pkg::OFFSET_LSB +: 5],
                    receive_slot_format_config[aipc_pkg::RX_EDGE_BIT]};

   // ------------------------------------------------------------
   // pulse-density clock and data
   // ------------------------------------------------------------
   logic pd_clk_meta;
   logic pd_clk_sync;
   logic pd_dat_meta;
   logic pd_dat_sync;

   always_ff @(posedge mclk)
   begin
      pd_clk_meta <= pd_clock_pin_a_in;
      pd_clk_sync <= pd_clk_meta;
      pd_dat_meta <= pd_data_in_a;
      pd_dat_sync <= pd_dat_meta;
   end

   logic [3:0] div_cnt;
   logic div_clk;
   wire div_wrap = (div_cnt == aipc_pkg::PD_DIV_LAST);
   wire pd_clk_enabled = pd_in_a_clock_gate & pd_in_a_clock_source;
   // master drives its own divided clock, slave follows the pin
   wire pd_clk_raw = pd_in_a_clock_role ? div_clk : pd_clk_sync;
   wire pd_clk_eff = pd_clk_enabled & pd_clk_raw;
   logic pd_clk_prev;
   wire pd_rise = pd_clk_eff & ~pd_clk_prev;
   wire pd_fall = ~pd_clk_eff & pd_clk_prev;
   wire pd_take = pd_in_a_capture_edge ? pd_fall : pd_rise;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         div_cnt <= 4'h0;
         div_clk <= 1'b0;
         pd_clk_prev <= 1'b0;
         pd_bit <= 1'b0;
         pd_bit_valid <= 1'b0;
         pd_clock_pin_a_out <= 1'b0;
         pd_clock_pin_a_oe <= 1'b0;
      end
      else
      begin
         div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
         if (div_wrap)
            div_clk <= ~div_clk;
         pd_clk_prev <= pd_clk_eff;
         pd_bit_valid <= pd_take;
         if (pd_take)
            pd_bit <= pd_dat_sync;
         pd_clock_pin_a_out <= pd_in_a_clock_role & pd_clk_enabled & div_clk;
         pd_clock_pin_a_oe <= pd_in_a_clock_role;
      end
   end

   // ------------------------------------------------------------
   // time-division receiver on the link clock
   // ------------------------------------------------------------
   aipc_pkg::aipc_sample_t rx_word;
   logic rx_word_toggle;
   logic rx_frame_toggle;

   aipc_tdm_rx u_rx (
      .serial_bit_clock(serial_bit_clock),
      .frame_sync(frame_sync),
      .serial_data_in(serial_data_in),
      .sys_rst(sys_rst),
      .cfg(rx_cfg),
      .word(rx_word),
      .word_toggle(rx_word_toggle),
      .frame_toggle(rx_frame_toggle)
   );

   // toggles cross in three stages; only the last two feed the edge test
   logic [2:0] word_tog_s;
   logic [2:0] frame_tog_s;
   wire word_evt = word_tog_s[2] ^ word_tog_s[1];
   wire frame_evt = frame_tog_s[2] ^ frame_tog_s[1];

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         word_tog_s <= 3'h0;
         frame_tog_s <= 3'h0;
         rx_sample <= 16'h0000;
         rx_sample_valid <= 1'b0;
      end
      else
      begin
         word_tog_s <= {word_tog_s[1:0], rx_word_toggle};
         frame_tog_s <= {frame_tog_s[1:0], rx_frame_toggle};
         rx_sample_valid <= word_evt;
         // the word stays put for most of a frame after its toggle
         if (word_evt)
            rx_sample <= rx_word;
      end
   end

   // ------------------------------------------------------------
   // sample rate detection and selection
   // ------------------------------------------------------------
   logic [11:0] period_cnt;
   logic [2:0] det_rate;
   wire [11:0] next_period = (period_cnt == 12'hfff) ? period_cnt : period_cnt + 12'h001;
   wire [2:0] next_det =
      (period_cnt > aipc_pkg::TH_1X_2X) ? aipc_pkg::RATE_1X :
      (period_cnt > aipc_pkg::TH_2X_4X) ? aipc_pkg::RATE_2X : aipc_pkg::RATE_4X;
   // reserved codes pass through unchanged; software keeps off them
   wire [2:0] next_active = auto_rate_off ? bus_sample_rate_code : det_rate;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         period_cnt <= 12'h000;
         det_rate <= aipc_pkg::RATE_1X;
         active_rate_code <= aipc_pkg::RATE_1X;
         amp_audio_clock_sync <= 1'b0;
         amp_rate_44k1 <= 1'b0;
      end
      else
      begin
         period_cnt <= frame_evt ? 12'h000 : next_period;
         if (frame_evt)
            det_rate <= next_det;
         active_rate_code <= next_active;
         amp_audio_clock_sync <= sync_bit;
         amp_rate_44k1 <= sync_bit & family_bit;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_pd_write;
      reg_wr && hit_pd;
   endsequence

   sequence s_pd_read;
      reg_rd && !reg_wr && hit_pd;
   endsequence

   AST_PD_RISE: assert property (
      (pd_rise && !pd_in_a_capture_edge) |=> (pd_bit_valid && pd_bit == $past(pd_dat_sync)))
      else $error("rising pulse-density edge not captured");

   AST_PD_FALL: assert property (
      (pd_rise && pd_in_a_capture_edge) |=> !pd_bit_valid)
      else $error("rising edge captured while falling edge selected");

   AST_PD_SLAVE: assert property (
      !pd_in_a_clock_role ##1 !pd_in_a_clock_role |-> (!pd_clock_pin_a_oe && !pd_clock_pin_a_out))
      else $error("slave drives the pulse-density clock");

   AST_PD_GROUND: assert property (
      (!pd_in_a_clock_source) [*3] |-> !pd_bit_valid)
      else $error("grounded pulse-density clock still captures");

   AST_PD_GATED: assert property (
      (!pd_in_a_clock_gate) [*3] |-> !pd_bit_valid)
      else $error("gated pulse-density clock still captures");

   AST_FAMILY: assert property (
      amp_rate_44k1 |-> ($past(family_bit) && amp_audio_clock_sync))
      else $error("44.1k family shown without sync and family bit");

   AST_SYNC: assert property (
      $rose(sync_bit) |=> amp_audio_clock_sync)
      else $error("amp sync not following its bit");

   AST_AUTO: assert property (
      (frame_evt && period_cnt > aipc_pkg::TH_1X_2X && !auto_rate_off) ##1 !auto_rate_off
         |=> (active_rate_code == aipc_pkg::RATE_1X))
      else $error("auto detection missed a base rate frame");

   AST_MANUAL: assert property (
      $past(auto_rate_off) |-> (active_rate_code == $past(bus_sample_rate_code)))
      else $error("programmed rate not used with detection off");

   AST_READBACK: assert property (
      (s_pd_write ##1 !reg_wr ##1 s_pd_read) |=> (reg_rdata == $past(reg_wdata, 3)))
      else $error("written value not read back");

endmodule

`default_nettype wire

// File: tb/aipc_src_model.sv
// source model: drives the time-division link pins one frame at a time
// assumes the bench calls its tasks; the link clock stands still between frames
`default_nettype none

module aipc_src_model (
   // link pins
   output var logic serial_bit_clock,
   output var logic frame_sync,
   output var logic serial_data_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      serial_bit_clock = 1'b0;
      frame_sync = 1'b1;
      serial_data_in = 1'b0;
   end

   // one 12 ns bit; pins move 3 ns after the edge opposite the capture edge
   task automatic bit_cyc(input logic fe, input logic fs, input logic d);
      #3;
      if (fe)
      begin
         serial_data_in = d;
         frame_sync = fs;
      end
      #3 serial_bit_clock = 1'b0;
      #3;
      if (!fe)
      begin
         serial_data_in = d;
         frame_sync = fs;
      end
      #3 serial_bit_clock = 1'b1;
   endtask

   task automatic run_idle(input int n);
      repeat (n) bit_cyc(1'b0, frame_sync, ~serial_data_in);
   endtask

   // outside the word the line shows the inverse of its last value
   task automatic send_frame(input logic pol, input logic fe, input logic right,
                             input logic [4:0] off, input logic [15:0] w);
      int start;
      logic d;
      start = off + (right ? 16 : 0);
      d = serial_data_in;
      for (int k = -2; k < start + 17; k++)
      begin
         if (k >= start && k < start + 16)
            d = w[15 - (k - start)];
         else
            d = ~d;
         bit_cyc(fe, (k == 0) ? ~pol : pol, d);
      end
   endtask
endmodule

`default_nettype wire

// File: tb/tb_aipc_audio_in.sv
// self-checking bench for the audio input port block
// assumes the source model drives the link and the bench drives all else
`default_nettype none

module tb_aipc_audio_in;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // signals and bench model
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_ack;
   logic pd_data_in_a = 1'b0;
   logic pd_clock_pin_a_in = 1'b0;
   logic pd_clock_pin_a_out, pd_clock_pin_a_oe, pd_bit, pd_bit_valid;
   wire serial_bit_clock, frame_sync, serial_data_in;
   aipc_pkg::aipc_sample_t rx_sample;
   logic rx_sample_valid, amp_audio_clock_sync, amp_rate_44k1;
   logic [2:0] active_rate_code;
   int fail_count = 0;
   int cmp_count = 0;
   int pd_n = 0;
   int regs [4];
   logic [31:0] seed = 32'd36;
   logic [7:0] rd_val;
   logic pd_chk = 1'b0;
   logic pd_q [$];
   logic [7:0] tc [6] = '{8'h81, 8'h01, 8'hc5, 8'h60, 8'hbf, 8'he2};

   always #50 mclk = ~mclk;

   aipc_audio_in uut (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .reg_ack, .pd_data_in_a, .pd_clock_pin_a_in, .pd_clock_pin_a_out,
      .pd_clock_pin_a_oe, .pd_bit, .pd_bit_valid, .serial_bit_clock, .frame_sync,
      .serial_data_in, .rx_sample, .rx_sample_valid, .active_rate_code,
      .amp_audio_clock_sync, .amp_rate_44k1);

   aipc_src_model src (.serial_bit_clock, .frame_sync, .serial_data_in);

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask

   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      reg_wr = wr;
      reg_rd = ~wr;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      chk(reg_ack, 1, "ack");
      rd_val = reg_rdata;
      if (wr && a >= 8'h08 && a <= 8'h0b)
         regs[a - 8'h08] = d;
   endtask

   task automatic rdreg(input logic [7:0] a);
      acc(1'b0, a, 8'h00);
      chk(rd_val, (a >= 8'h08 && a <= 8'h0b) ? regs[a - 8'h08] : 0, "rdata");
   endtask

   // slave clock half period of 3 mclk; data moves on the edge not captured
   task automatic pd_run(input int n, input logic e);
      repeat (n)
      begin
         cyc(3);
         pd_clock_pin_a_in = ~pd_clock_pin_a_in;
         if (pd_clock_pin_a_in == ~e)
            pd_q.push_back(pd_data_in_a);
         else
            pd_data_in_a = 1'(xs());
      end
      cyc(6);
   endtask

   task automatic get_word(input logic [15:0] w);
      int k;
      k = 0;
      while (rx_sample_valid !== 1'b1)
      begin
         cyc(1);
         k++;
         if (k > 40)
         begin
            fail_count++;
            end_of_test();
         end
      end
      chk(rx_sample, w, "sample");
   endtask

   always @(negedge mclk)
      if (pd_bit_valid === 1'b1)
      begin
         pd_n++;
         if (pd_chk)
            chk(pd_bit, (pd_q.size() > 0) ? pd_q.pop_front() : 1'bx, "pd bit");
      end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      int tog;
      int n0;
      logic [15:0] w;
      logic [7:0] a;
      logic [2:0] rc [3] = '{aipc_pkg::RATE_1X, aipc_pkg::RATE_2X, aipc_pkg::RATE_4X};
      int sp [3] = '{200, 100, 60};
      regs = '{aipc_pkg::AMP_SYNC_RST, aipc_pkg::PD_CFG_RST, aipc_pkg::FRAME_CFG_RST,
               aipc_pkg::SLOT_CFG_RST};
      #1 src.run_idle(20);
      cyc(2);
      sys_rst = 1'b0;
      chk(active_rate_code, aipc_pkg::RATE_1X, "rate rst");
      for (int i = 7; i <= 12; i++)
         rdreg(8'(i));
      repeat (8)
      begin
         a = 8'h08 + 8'(2'(xs()));
         acc(1'b1, a, 8'(xs()));
         rdreg(a);
      end
      for (int e = 0; e < 2; e++)
      begin
         pd_chk = 1'b0;
         acc(1'b1, aipc_pkg::PD_CFG_ADDR, {e[0], 7'h0a});
         cyc(2);
         pd_q.delete();
         pd_chk = 1'b1;
         pd_run(16, e[0]);
         chk(16'(pd_q.size()), 0, "pd left");
         chk(pd_clock_pin_a_oe, 0, "slave oe");
      end
      pd_chk = 1'b0;
      for (int v = 0; v < 2; v++)
      begin
         acc(1'b1, aipc_pkg::PD_CFG_ADDR, v ? 8'h22 : 8'h28);
         n0 = pd_n;
         pd_run(8, 1'b0);
         chk(16'(pd_n - n0), 0, "gated");
         chk(pd_clock_pin_a_out, 0, "clk out");
      end
      acc(1'b1, aipc_pkg::PD_CFG_ADDR, 8'h2a);
      cyc(4);
      tog = 0;
      repeat (40)
      begin
         a[0] = pd_clock_pin_a_out;
         cyc(1);
         tog += (a[0] !== pd_clock_pin_a_out);
      end
      chk(16'(tog), 20, "master clk");
      chk(pd_clock_pin_a_oe, 1, "master oe");
      for (int i = 0; i < 4; i++)
      begin
         acc(1'b1, aipc_pkg::AMP_SYNC_ADDR, {1'b0, i[1], 6'h00});
         acc(1'b1, aipc_pkg::FRAME_CFG_ADDR, {2'b00, i[0], 1'b1, aipc_pkg::RATE_1X, 1'b1});
         cyc(3);
         chk(amp_audio_clock_sync, i[1], "sync");
         chk(amp_rate_44k1, i[1] & i[0], "family");
      end
      foreach (tc[i])
      begin
         acc(1'b1, aipc_pkg::FRAME_CFG_ADDR, {4'h1, aipc_pkg::RATE_1X, tc[i][7]});
         acc(1'b1, aipc_pkg::SLOT_CFG_ADDR, {i[0], tc[i][5], tc[i][4:0], tc[i][6]});
         cyc(50);
         w = 16'(xs());
         src.send_frame(tc[i][7], tc[i][6], tc[i][5], tc[i][4:0], w);
         get_word(w);
      end
      acc(1'b1, aipc_pkg::FRAME_CFG_ADDR, 8'h07);
      foreach (sp[i])
      begin
         repeat (3)
         begin
            src.send_frame(1'b1, 1'b0, 1'b0, 5'h01, 16'h0000);
            cyc(sp[i]);
         end
         chk(active_rate_code, rc[i], "detected");
      end
      foreach (rc[i])
      begin
         acc(1'b1, aipc_pkg::FRAME_CFG_ADDR, {4'h1, rc[i], 1'b1});
         cyc(4);
         chk(active_rate_code, rc[i], "programmed");
      end
      end_of_test();
   end
endmodule

`default_nettype wire
